// ### rtl/lmc_pkg.sv
// Package of constants for the local monitor console block
package lmc_pkg;
  // Serial timing
  localparam int          CLK_HZ         = 50000000;
  localparam int          BAUD_RATE      = 1200;
  localparam int          BIT_CYCLES     = CLK_HZ / BAUD_RATE;
  localparam int          HALF_CYCLES    = BIT_CYCLES / 2;
  localparam int          DATA_BITS      = 8;
  localparam int          STOP_BITS      = 1;
  // Command characters, upper case only
  localparam logic [7:0]  CMD_STATUS     = 8'h53;
  localparam logic [7:0]  CMD_TEST       = 8'h54;
  // Dual-port word indices
  localparam logic [4:0]  ADR_DROP_A     = 5'h04;
  localparam logic [4:0]  ADR_DROP_D     = 5'h07;
  localparam logic [4:0]  ADR_MSG_RX     = 5'h0E;
  localparam logic [4:0]  ADR_RX_TMO     = 5'h0F;
  localparam logic [4:0]  ADR_CRC_ERR    = 5'h10;
  localparam logic [4:0]  ADR_OVR_ERR    = 5'h11;
  localparam logic [4:0]  ADR_ABT_ERR    = 5'h12;
  localparam logic [4:0]  ADR_MSG_TX     = 5'h13;
  localparam logic [4:0]  ADR_DEPTH      = 5'h14;
  localparam logic [15:0] DEPTH_RESET    = 16'h0000;
  localparam int          NUM_DROPS      = 56;
  localparam logic [5:0]  MAX_DROP       = 6'h37;
  localparam int          NUM_CNT        = 6;
  // Self test duration in clock cycles
  localparam int          TEST_CYCLES    = 1000;
  // Arbitrary part identity value
  localparam logic [15:0] PART_ID        = 16'h1234;
  // Report byte count: part, chassis, line, mode, drop, 6 counters x2, 7 drop bytes
  localparam int          REPORT_BYTES   = 5 + 2 * NUM_CNT + 7;
  typedef enum logic [3:0] {
    LMC_IDLE  = 4'h1,
    LMC_LOAD  = 4'h2,
    LMC_SEND  = 4'h4,
    LMC_TEST  = 4'h8
  } lmc_state_t;
endpackage : lmc_pkg

// ### rtl/lmc_uart.sv
// Serial receiver and transmitter, 8 data bits, 1 stop, no parity
`timescale 1ns/1ps
module lmc_uart
  import lmc_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYCLES  // Bit time in clocks, default is 1200 baud
)
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       rxd,
  output logic            txd,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic        rx_s1_q;
  logic        rx_s2_q;
  logic [15:0] rx_cnt_q;
  logic [3:0]  rx_bit_q;
  logic [8:0]  rx_sh_q;
  logic        rx_busy_q;
  logic [15:0] tx_cnt_q;
  logic [3:0]  tx_bit_q;
  logic [9:0]  tx_sh_q;
  logic        tx_busy_q;
  wire         rx_tick = (rx_cnt_q == 16'h0000);
  wire         tx_tick = (tx_cnt_q == 16'h0000);

  // Pin synchroniser
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end
    else
    begin
      rx_s1_q <= rxd;
      rx_s2_q <= rx_s1_q;
    end

  // Receiver samples mid-bit
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      rx_busy_q <= 1'b0;
      rx_cnt_q  <= 16'h0000;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 9'h000;
      rx_valid  <= 1'b0;
      rx_data   <= 8'h00;
    end
    else
    begin
      rx_valid <= 1'b0;
      if (!rx_busy_q)
      begin
        if (!rx_s2_q)
        begin
          rx_busy_q <= 1'b1;
          rx_cnt_q  <= 16'(BIT_CYC / 2);
          rx_bit_q  <= 4'h0;
        end
      end
      else if (!rx_tick)
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      else
      begin
        rx_cnt_q <= 16'(BIT_CYC - 1);
        rx_sh_q  <= {rx_s2_q, rx_sh_q[8:1]};
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'(DATA_BITS + STOP_BITS))
        begin
          rx_busy_q <= 1'b0;
          rx_valid  <= rx_s2_q;  // Frame valid only with stop bit high
          rx_data   <= rx_sh_q[8:1];
        end
      end
    end

  // Transmitter shifts start, data, stop
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      tx_busy_q <= 1'b0;
      tx_cnt_q  <= 16'h0000;
      tx_bit_q  <= 4'h0;
      tx_sh_q   <= 10'h3FF;
      txd       <= 1'b1;
    end
    else if (!tx_busy_q)
    begin
      txd <= 1'b1;
      if (tx_valid)
      begin
        tx_busy_q <= 1'b1;
        tx_sh_q   <= {1'b1, tx_data, 1'b0};
        tx_bit_q  <= 4'h0;
        tx_cnt_q  <= 16'h0000;
      end
    end
    else if (!tx_tick)
      tx_cnt_q <= tx_cnt_q - 16'h0001;
    else if (tx_bit_q == 4'(DATA_BITS + 2))
      tx_busy_q <= 1'b0;
    else
    begin
      txd      <= tx_sh_q[0];
      tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
      tx_bit_q <= tx_bit_q + 4'h1;
      tx_cnt_q <= 16'(BIT_CYC - 1);
    end

  assign tx_ready = !tx_busy_q;
endmodule : lmc_uart

// ### rtl/lmc_console.sv
// Local monitor console: command interpreter, statistics, self test, scheduler
`timescale 1ns/1ps
module lmc_console
  import lmc_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYCLES  // Bit time in clocks, default is 1200 baud
)
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        rxd,
  output logic             txd,
  input  wire logic [5:0]  drop_switch,
  input  wire logic        is_master,
  input  wire logic        key_program,
  input  wire logic        key_protect,
  input  wire logic        net_connected,
  input  wire logic        chassis_active,
  input  wire logic        line_active,
  input  wire logic        ev_msg_rx,
  input  wire logic        ev_msg_tx,
  input  wire logic        ev_err_own,
  input  wire logic [1:0]  ev_err_kind,
  input  wire logic        ev_err_other,
  input  wire logic [55:0] drop_live,
  input  wire logic [55:0] tx_request,
  input  wire logic        tx_slot,
  output logic             tx_grant_valid,
  output logic [5:0]       tx_grant_drop,
  input  wire logic        bp_req,
  input  wire logic        bp_we,
  input  wire logic [4:0]  bp_addr,
  input  wire logic [15:0] bp_wdata,
  output logic             bp_ack,
  output logic             bp_berr,
  output logic [15:0]      bp_rdata,
  output logic             comm_fail,
  output logic             self_test_busy,
  output logic [5:0]       drop_number
);
  lmc_state_t  state_q;
  logic [15:0] cnt_q [NUM_CNT];
  logic [15:0] depth_q;
  logic        fail_q;
  logic [55:0] drop_shown_q;
  logic [55:0] served_q;
  logic [15:0] test_cnt_q;
  logic [4:0]  rep_idx_q;
  logic [7:0]  tx_byte_q;
  logic        tx_go_q;
  logic [5:0]  sw1_q;
  logic [5:0]  sw2_q;
  logic [2:0]  st_s1_q;
  logic [2:0]  st_s2_q;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        tx_ready;
  logic [7:0]  rep_byte;
  logic [1:0]  mode_code;

  // Serial port
  lmc_uart #(.BIT_CYC (BIT_CYC)) u_uart (
    .clk      (clk),
    .arst_n   (arst_n),
    .rxd      (rxd),
    .txd      (txd),
    .rx_valid (rx_valid),
    .rx_data  (rx_data),
    .tx_valid (tx_go_q),
    .tx_data  (tx_byte_q),
    .tx_ready (tx_ready)
  );

  // Switch and status pin synchronisers
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      sw1_q   <= 6'h00;
      sw2_q   <= 6'h00;
      st_s1_q <= 3'h0;
      st_s2_q <= 3'h0;
    end
    else
    begin
      sw1_q   <= drop_switch;
      sw2_q   <= sw1_q;
      st_s1_q <= {key_program, key_protect, net_connected};
      st_s2_q <= st_s1_q;
    end

  wire key_prog_s  = st_s2_q[2];
  wire key_prot_s  = st_s2_q[1];
  wire net_conn_s  = st_s2_q[0];

  // Command decode
  wire cmd_status  = rx_valid && (rx_data == CMD_STATUS);
  wire cmd_test    = rx_valid && (rx_data == CMD_TEST);
  wire test_ok     = key_prog_s && !net_conn_s;
  wire idle        = (state_q == LMC_IDLE);
  wire start_rep   = idle && cmd_status;
  wire start_test  = idle && cmd_test && test_ok;
  wire test_done   = (state_q == LMC_TEST) && (test_cnt_q == 16'h0000);
  wire rep_last    = (rep_idx_q == 5'(REPORT_BYTES - 1));

  // Mode: 0 program, 1 memory protect, 2 setup
  assign mode_code = key_prog_s ? 2'h0 : (key_prot_s ? 2'h1 : 2'h2);

  // Represented drop window for a slave
  wire [6:0] drop_hi = 7'(drop_number) + 7'(depth_q[6:0]);
  logic [55:0] drop_mask;
  always_comb
  begin
    for (int i = 0; i < NUM_DROPS; i++)
      drop_mask[i] = is_master ||
                     ((7'(i) >= 7'(drop_number)) && (7'(i) < drop_hi));
  end

  // Report byte selection
  wire [4:0] cidx  = rep_idx_q - 5'h05;
  wire [2:0] cnum  = cidx[3:1];
  wire [2:0] didx  = 3'(rep_idx_q - 5'h11);
  wire [63:0] drop_ext = {8'h00, drop_shown_q};
  always_comb
  begin
    if (rep_idx_q == 5'h00)
      rep_byte = PART_ID[7:0];
    else if (rep_idx_q == 5'h01)
      rep_byte = {7'h00, chassis_active};
    else if (rep_idx_q == 5'h02)
      rep_byte = {7'h00, line_active};
    else if (rep_idx_q == 5'h03)
      rep_byte = {6'h00, mode_code};
    else if (rep_idx_q == 5'h04)
      rep_byte = {2'h0, drop_number};
    else if (rep_idx_q < 5'h11)
      rep_byte = cidx[0] ? cnt_q[cnum][7:0] : cnt_q[cnum][15:8];
    else
      rep_byte = drop_ext[8*didx +: 8];
  end

  // Console state machine
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      state_q      <= LMC_IDLE;
      rep_idx_q    <= 5'h00;
      tx_go_q      <= 1'b0;
      tx_byte_q    <= 8'h00;
      test_cnt_q   <= 16'h0000;
      drop_shown_q <= 56'h0;
    end
    else
    begin
      tx_go_q <= 1'b0;
      case (state_q)
        LMC_IDLE:
        begin
          if (start_rep)
          begin
            rep_idx_q    <= 5'h00;
            drop_shown_q <= drop_live & drop_mask;
            state_q      <= LMC_LOAD;
          end
          else if (start_test)
          begin
            test_cnt_q <= 16'(TEST_CYCLES - 1);
            state_q    <= LMC_TEST;
          end
        end
        LMC_LOAD:
        begin
          if (tx_ready && !tx_go_q)
          begin
            tx_byte_q <= rep_byte;
            tx_go_q   <= 1'b1;
            state_q   <= LMC_SEND;
          end
        end
        LMC_SEND:
        begin
          if (!tx_go_q)
          begin
            rep_idx_q <= rep_idx_q + 5'h01;
            state_q   <= rep_last ? LMC_IDLE : LMC_LOAD;
          end
        end
        LMC_TEST:
        begin
          test_cnt_q <= test_cnt_q - 16'h0001;
          if (test_done)
            state_q <= LMC_IDLE;
        end
        default:
          state_q <= LMC_IDLE;
      endcase
    end

  assign self_test_busy = (state_q == LMC_TEST);

  // Drop number capture once the switch synchroniser has filled, and at the end of self test
  logic [2:0] first_q;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      first_q     <= 3'h1;
      drop_number <= 6'h00;
    end
    else
    begin
      first_q <= {first_q[1:0], 1'b0};
      if (first_q[2] || test_done)
        drop_number <= (sw2_q > MAX_DROP) ? MAX_DROP : sw2_q;
    end

  // Backplane access decode
  wire bp_ok     = bp_req && !self_test_busy;
  wire wr_depth  = bp_ok && bp_we && (bp_addr == ADR_DEPTH);
  wire is_cnt    = (bp_addr >= ADR_MSG_RX) && (bp_addr <= ADR_MSG_TX);
  wire is_drop   = (bp_addr >= ADR_DROP_A) && (bp_addr <= ADR_DROP_D);
  wire [2:0] rd_cnt  = 3'(bp_addr - ADR_MSG_RX);
  wire [1:0] rd_drp  = 2'(bp_addr - ADR_DROP_A);
  wire [63:0] live_ext = {8'h00, drop_live};
  wire [15:0] rd_val = is_cnt  ? cnt_q[rd_cnt] :
                       is_drop ? live_ext[16*rd_drp +: 16] :
                       (bp_addr == ADR_DEPTH) ? {fail_q, 15'h0000} | depth_q :
                       16'h0000;
  wire bp_bad_wr = bp_we && (bp_addr != ADR_DEPTH);

  // Backplane answer
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      bp_ack   <= 1'b0;
      bp_berr  <= 1'b0;
      bp_rdata <= 16'h0000;
    end
    else
    begin
      bp_ack   <= bp_ok && !bp_bad_wr;
      bp_berr  <= bp_req && (self_test_busy || bp_bad_wr);
      bp_rdata <= bp_ok ? rd_val : 16'h0000;
    end

  // Drop depth and failure code
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      depth_q <= DEPTH_RESET;
      fail_q  <= 1'b1;
    end
    else if (test_done)
    begin
      depth_q <= DEPTH_RESET;
      fail_q  <= 1'b1;
    end
    else if (wr_depth)
    begin
      depth_q <= {1'b0, bp_wdata[14:0]};
      fail_q  <= (bp_wdata[14:0] == 15'h0000);
    end

  assign comm_fail = fail_q;

  // Statistics counters, 16-bit wrapping
  wire err_hit = ev_err_own || (is_master && ev_err_other);
  logic [NUM_CNT-1:0] inc;
  always_comb
  begin
    inc    = '0;
    inc[0] = ev_msg_rx;
    inc[5] = ev_msg_tx;
    inc[3'(ev_err_kind) + 3'h1] = err_hit;
  end
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      for (int k = 0; k < NUM_CNT; k++)
        cnt_q[k] <= 16'h0000;
    end
    else if (test_done)
    begin
      for (int k = 0; k < NUM_CNT; k++)
        cnt_q[k] <= 16'h0000;
    end
    else
    begin
      for (int k = 0; k < NUM_CNT; k++)
        if (inc[k])
          cnt_q[k] <= cnt_q[k] + 16'h0001;
    end

  // Round robin grant: pending requests not yet served this round
  wire [55:0] pend     = tx_request & ~served_q;
  wire        round_end = (tx_request != 56'h0) && (pend == 56'h0);
  logic [5:0] pick;
  logic       found;
  always_comb
  begin
    pick  = 6'h00;
    found = 1'b0;
    for (int j = NUM_DROPS - 1; j >= 0; j--)
      if (pend[j])
      begin
        pick  = 6'(j);
        found = 1'b1;
      end
  end
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      served_q       <= 56'h0;
      tx_grant_valid <= 1'b0;
      tx_grant_drop  <= 6'h00;
    end
    else
    begin
      tx_grant_valid <= 1'b0;
      if (tx_slot && round_end)
        served_q <= 56'h0;
      else if (tx_slot && found)
      begin
        served_q[pick] <= 1'b1;
        tx_grant_valid <= 1'b1;
        tx_grant_drop  <= pick;
      end
    end

  // Checks
  property p_berr_test;
    @(posedge clk) disable iff (!arst_n)
      (bp_req && self_test_busy) |=> (bp_berr && !bp_ack);
  endproperty
  a_berr_test: assert property (p_berr_test) else $error("access during test not refused");

  property p_test_gate;
    @(posedge clk) disable iff (!arst_n)
      (idle && $rose(self_test_busy) == 1'b0 && cmd_test && !test_ok) |=> !self_test_busy;
  endproperty
  a_test_gate: assert property (p_test_gate) else $error("self test not gated");

  property p_test_end;
    @(posedge clk) disable iff (!arst_n)
      test_done |=> (depth_q == 16'h0000) && comm_fail;
  endproperty
  a_test_end: assert property (p_test_end) else $error("test end state wrong");

  property p_depth_clear;
    @(posedge clk) disable iff (!arst_n)
      (wr_depth && !test_done && bp_wdata[14:0] != 15'h0000) |=> !comm_fail;
  endproperty
  a_depth_clear: assert property (p_depth_clear) else $error("failure code not cleared");

  property p_wrap;
    @(posedge clk) disable iff (!arst_n)
      (inc[5] && !test_done && cnt_q[5] == 16'hFFFF) |=> (cnt_q[5] == 16'h0000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_no_repeat;
    @(posedge clk) disable iff (!arst_n)
      tx_grant_valid |-> (($past(served_q) & (56'h1 << tx_grant_drop)) == 56'h0);
  endproperty
  a_no_repeat: assert property (p_no_repeat) else $error("drop granted twice in round");

  property p_cmd_only;
    @(posedge clk) disable iff (!arst_n)
      (idle && rx_valid && rx_data != CMD_STATUS && rx_data != CMD_TEST) |=> idle;
  endproperty
  a_cmd_only: assert property (p_cmd_only) else $error("unknown command acted on");

  sequence s_status_cmd;
    idle && cmd_status;
  endsequence
  property p_report;
    @(posedge clk) disable iff (!arst_n)
      s_status_cmd |=> (state_q == LMC_LOAD) && (rep_idx_q == 5'h00);
  endproperty
  a_report: assert property (p_report) else $error("report not started");

  property p_master_err;
    @(posedge clk) disable iff (!arst_n)
      (is_master && ev_err_other && !ev_err_own && !test_done && ev_err_kind == 2'h0)
      |=> (cnt_q[1] == $past(cnt_q[1]) + 16'h0001);
  endproperty
  a_master_err: assert property (p_master_err) else $error("network error not counted");
endmodule : lmc_console

// ### bench/lmc_terminal.sv
// Operator terminal model on the serial console link
`timescale 1ns/1ps
module lmc_terminal
  import lmc_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYCLES
)
(
  input  wire logic clk,
  output logic      rxd,
  input  wire logic txd
);
  // Line idles high between characters
  initial rxd = 1'b1;
  // Send one character: start, 8 data LSB first, one stop, no parity
  task automatic send_char(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd = f[i];
      repeat (BIT_CYC) @(negedge clk);
    end
  endtask : send_char
  // Receive one character, sampled mid-bit; ok low on no start or bad stop
  task automatic recv_char(output logic [7:0] c, output logic ok);
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 16 * BIT_CYC)
    begin
      @(negedge clk);
      n++;
    end
    repeat (BIT_CYC / 2) @(negedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(negedge clk);
      c[i] = txd;
    end
    repeat (BIT_CYC) @(negedge clk);
    ok = (txd === 1'b1) && (n < 16 * BIT_CYC);
  endtask : recv_char
endmodule : lmc_terminal

// ### bench/tb_local_monitor_console.sv
// Self-checking bench for the local monitor console
`timescale 1ns/1ps
module tb_local_monitor_console;
  import lmc_pkg::*;
  // Short bit time keeps the run brief; framing does not depend on the rate
  localparam int TB_BIT = 16;
  logic        clk = 1'b0, arst_n = 1'b0, rxd, txd;
  logic [5:0]  drop_switch = 6'h2A, tx_grant_drop, drop_number, gd, dn;
  logic        is_master = 1'b0, key_program = 1'b1, key_protect = 1'b0;
  logic        net_connected = 1'b1, chassis_active = 1'b1, line_active = 1'b0;
  logic        ev_msg_rx = 1'b0, ev_msg_tx = 1'b0, ev_err_own = 1'b0, ev_err_other = 1'b0;
  logic [1:0]  ev_err_kind = 2'h0;
  logic [55:0] drop_live = 56'h0, tx_request = 56'h0, served, shown;
  logic        tx_slot = 1'b0, bp_req = 1'b0, bp_we = 1'b0;
  logic [4:0]  bp_addr = 5'h00;
  logic [15:0] bp_wdata = 16'h0000, bp_rdata, rd, d;
  logic        tx_grant_valid, bp_ack, bp_berr, comm_fail, self_test_busy;
  logic        ak, be, gv, ok;
  logic [6:0]  e;
  logic [7:0]  c;
  logic [15:0] cnt [6];
  int          errors = 0, samples_checked = 0, n;

  // 50 MHz clock
  always #10 clk = ~clk;

  lmc_console #(.BIT_CYC(TB_BIT)) i_dut (.clk(clk), .arst_n(arst_n), .rxd(rxd), .txd(txd),
    .drop_switch(drop_switch), .is_master(is_master), .key_program(key_program),
    .key_protect(key_protect), .net_connected(net_connected),
    .chassis_active(chassis_active), .line_active(line_active), .ev_msg_rx(ev_msg_rx),
    .ev_msg_tx(ev_msg_tx), .ev_err_own(ev_err_own), .ev_err_kind(ev_err_kind),
    .ev_err_other(ev_err_other), .drop_live(drop_live), .tx_request(tx_request),
    .tx_slot(tx_slot), .tx_grant_valid(tx_grant_valid), .tx_grant_drop(tx_grant_drop),
    .bp_req(bp_req), .bp_we(bp_we), .bp_addr(bp_addr), .bp_wdata(bp_wdata),
    .bp_ack(bp_ack), .bp_berr(bp_berr), .bp_rdata(bp_rdata), .comm_fail(comm_fail),
    .self_test_busy(self_test_busy), .drop_number(drop_number));

  lmc_terminal #(.BIT_CYC(TB_BIT)) i_term (.clk(clk), .rxd(rxd), .txd(txd));

  // Compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // One backplane access, answer captured within two cycles
  task automatic bp(input logic we, input logic [4:0] a, input logic [15:0] wd);
    @(negedge clk);
    {bp_req, bp_we, bp_addr, bp_wdata} = {1'b1, we, a, wd};
    @(negedge clk);
    bp_req = 1'b0;
    {ak, be, rd} = 18'h0;
    repeat (2)
    begin
      if (bp_ack === 1'b1 || bp_berr === 1'b1) {ak, be, rd} = {bp_ack, bp_berr, bp_rdata};
      @(negedge clk);
    end
  endtask : bp

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] ex);
    bp(1'b0, a, 16'h0000);
    check({be, ak, rd}, {2'b01, ex});
  endtask : rd_chk

  // Pulse one event input n times: 0 rx, 1 tx, 2 own error, 3 other error
  task automatic pulse(input int w, input int k);
    repeat (k)
    begin
      @(negedge clk);
      {ev_err_other, ev_err_own, ev_msg_tx, ev_msg_rx} = 4'h1 << w;
      @(negedge clk);
      {ev_err_other, ev_err_own, ev_msg_tx, ev_msg_rx} = 4'h0;
    end
  endtask : pulse

  // Offer one transmit slot, capture any grant
  task automatic slot();
    @(negedge clk);
    tx_slot = 1'b1;
    @(negedge clk);
    tx_slot = 1'b0;
    {gv, gd} = 7'h00;
    repeat (2)
    begin
      if (tx_grant_valid === 1'b1) {gv, gd} = {1'b1, tx_grant_drop};
      @(negedge clk);
    end
  endtask : slot

  task automatic wait_busy(input logic v, input int lim);
    for (int i = 0; i < lim && self_test_busy !== v; i++) @(negedge clk);
  endtask : wait_busy

  // Lowest pending drop not yet served this round
  function automatic logic [6:0] next_grant(input logic [55:0] q);
    for (int i = 0; i < NUM_DROPS; i++)
      if (q[i]) return {1'b1, 6'(i)};
    return 7'h00;
  endfunction : next_grant

  // Expected report byte: header, counters high byte first, shown drop bits
  function automatic logic [7:0] exp_byte(input int i, input logic [5:0] dr,
                                          input logic [7:0] md, input logic [55:0] sh);
    logic [63:0] w;
    w = {8'h00, sh};
    case (i)
      0: return PART_ID[7:0];
      1: return {7'h00, chassis_active};
      2: return {7'h00, line_active};
      3: return md;
      4: return {2'h0, dr};
      default:
        if (i < 17) return (i % 2) ? cnt[(i - 5) / 2][15:8] : cnt[(i - 5) / 2][7:0];
        else return w[8 * (i - 17) +: 8];
    endcase
  endfunction : exp_byte

  // Rack processor side: this block asks for no interrupt line
  // Watchdog, about 100000 cycles
  initial
  begin
    #(64'd2_000_000);
    errors++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'h0430));
    foreach (cnt[i]) cnt[i] = 16'h0000;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    check({comm_fail, drop_number}, {1'b1, 6'h2A});
    rd_chk(ADR_DEPTH, 16'h8000);
    d = 16'(($urandom % 16'h7FFF) + 1);
    bp(1'b1, ADR_DEPTH, d);
    check({be, ak}, 2'b01);
    rd_chk(ADR_DEPTH, d);
    check(comm_fail, 1'b0);
    bp(1'b1, ADR_MSG_RX, 16'hFFFF);
    check({be, ak}, 2'b10);
    // Statistics counters, own and network-wide errors
    n = $urandom % 5 + 1;
    pulse(0, n);
    cnt[0] += 16'(n);
    for (int k = 0; k < 4; k++)
    begin
      ev_err_kind = 2'(k);
      n = $urandom % 4 + 1;
      is_master = 1'b0;
      pulse(2, n);
      pulse(3, 1);
      is_master = 1'b1;
      pulse(3, 2);
      cnt[k + 1] += 16'(n + 2);
    end
    pulse(1, 3);
    cnt[5] += 16'h0003;
    for (int i = 0; i < NUM_CNT; i++) rd_chk(5'(ADR_MSG_RX + i), cnt[i]);
    // One long burst of 65536 sends brings the counter full circle
    @(negedge clk);
    ev_msg_tx = 1'b1;
    repeat (65536) @(negedge clk);
    ev_msg_tx = 1'b0;
    rd_chk(ADR_MSG_TX, cnt[5]);
    // Drop status words
    drop_live = 56'({$urandom, $urandom});
    for (int i = 0; i < 4; i++) rd_chk(5'(ADR_DROP_A + i), 16'(drop_live >> (16 * i)));
    // Round robin over two rounds
    tx_request = (56'h1 << ($urandom % 56)) | 56'h80_0000_0000_0001 | (56'h1 << drop_number);
    for (int r = 0; r < 2; r++)
    begin
      served = 56'h0;
      for (int s = 0; s < 5; s++)
      begin
        e = next_grant(tx_request & ~served);
        slot();
        check({gv, gd}, e);
        if (e[6]) served[e[5:0]] = 1'b1;
        else break;
      end
    end
    // Refused self test commands: lower case, then on-line
    net_connected = 1'b0;
    i_term.send_char(8'h74);
    net_connected = 1'b1;
    i_term.send_char(CMD_TEST);
    rd_chk(ADR_DEPTH, d);
    // Accepted self test with new drop switch
    net_connected = 1'b0;
    dn = 6'($urandom % 56);
    drop_switch = dn;
    fork
      i_term.send_char(CMD_TEST); // Backplane write tried once busy rises, while the stop bit still goes out
      begin
        wait_busy(1'b1, 11 * TB_BIT);
        check(self_test_busy, 1'b1);
        bp(1'b1, ADR_DEPTH, 16'h0005);
        check({be, ak}, 2'b10);
        wait_busy(1'b0, 2 * TEST_CYCLES);
      end
    join
    check({comm_fail, drop_number}, {1'b1, dn});
    rd_chk(ADR_DEPTH, 16'h8000);
    rd_chk(ADR_MSG_TX, 16'h0000);
    // Full slave report over a represented window
    foreach (cnt[i]) cnt[i] = 16'h0000;
    pulse(0, 3);
    cnt[0] = 16'h0003;
    is_master = 1'b0;
    d = 16'($urandom % 8 + 1);
    bp(1'b1, ADR_DEPTH, d);
    check({be, ak, comm_fail}, 3'b010);
    shown = drop_live & (((56'h1 << d) - 56'h1) << dn);
    fork
      i_term.send_char(CMD_STATUS);
      for (int i = 0; i < REPORT_BYTES; i++)
      begin
        i_term.recv_char(c, ok);
        check({ok, c}, {1'b1, exp_byte(i, dn, 8'h00, shown)});
      end
    join
    // Fresh report on a new command, memory protect mode
    key_program = 1'b0;
    key_protect = 1'b1;
    fork
      i_term.send_char(CMD_STATUS);
      for (int i = 0; i < 4; i++)
      begin
        i_term.recv_char(c, ok);
        check({ok, c}, {1'b1, exp_byte(i, dn, 8'h01, shown)});
      end
    join
    give_verdict();
  end
endmodule : tb_local_monitor_console
